// ---- core/over_voltage_guard_ctrl.sv ----
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module over_voltage_guard_ctrl
  import ovg_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       cmp_raw,
  output logic            cmp_power_en,
  output logic            dac_power_en,
  output logic            cmp_hysteresis_en,
  output logic            dac_ref_select,
  output logic      [7:0] threshold_dac_code,
  output logic      [4:0] offset_trim,
  output logic            cal_mode,
  output logic            cal_ref_select,
  output logic      [2:0] switch_close,
  output logic            irq_req
);

  // Software-visible control state
  logic       protect_enable_q;
  logic       hyst_q;
  logic       ref_sel_q;
  logic [1:0] debounce_select_q;
  logic       cal_mode_q;
  logic       cal_ref_q;
  logic [4:0] trim_q;
  logic [7:0] dac_code_q;
  logic [7:0] rdata_q;
  logic [2:0] switch_q;
  logic       irq_q;

  // Comparator sampling path
  logic       cmp_meta_q;
  logic       cmp_sync_q;
  logic       cmp_result;
  logic       cmp_rise;
  logic [5:0] deb_limit;

  // Switch pattern for a given mode and calibration reference
  function automatic logic [2:0] switch_map(input logic mode, input logic cref);
    logic [2:0] s;
    s = 3'h0;
    if (!mode) begin
      s = 3'h3;
    end else if (!cref) begin
      s = 3'h6;
    end else begin
      s = 3'h1;
    end
    return s;
  endfunction : switch_map

  // Debounce field to stability limit
  function automatic logic [5:0] deb_map(input logic [1:0] sel);
    logic [5:0] l;
    l = DEB_LIMIT_NONE;
    case (sel)
      2'h0:    l = DEB_LIMIT_NONE;
      2'h1:    l = DEB_LIMIT_8;
      2'h2:    l = DEB_LIMIT_16;
      2'h3:    l = DEB_LIMIT_32;
      default: l = DEB_LIMIT_NONE;
    endcase
    return l;
  endfunction : deb_map

  // protect_control writes
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      protect_enable_q  <= PROTECT_EN_RST;
      hyst_q            <= HYST_EN_RST;
      ref_sel_q         <= DAC_REF_SEL_RST;
      debounce_select_q <= DEB_SEL_RST;
    end else if (reg_wr && reg_addr == ADDR_PROTECT_CTRL) begin
      protect_enable_q  <= reg_wdata[BIT_PROTECT_EN];
      hyst_q            <= reg_wdata[BIT_HYST_EN];
      ref_sel_q         <= reg_wdata[BIT_DAC_REF_SEL];
      debounce_select_q <= reg_wdata[BIT_DEB_HI:BIT_DEB_LO];
    end
  end

  // comparator_trim_control writes; result bit is read only
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cal_mode_q <= CAL_MODE_RST;
      cal_ref_q  <= CAL_REF_SEL_RST;
      trim_q     <= TRIM_RST;
    end else if (reg_wr && reg_addr == ADDR_TRIM_CTRL) begin
      cal_mode_q <= reg_wdata[BIT_CAL_MODE];
      cal_ref_q  <= reg_wdata[BIT_CAL_REF_SEL];
      trim_q     <= reg_wdata[BIT_TRIM_HI:BIT_TRIM_LO];
    end
  end

  // threshold_dac_code writes
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dac_code_q <= DAC_CODE_RST;
    end else if (reg_wr && reg_addr == ADDR_DAC_CODE) begin
      dac_code_q <= reg_wdata;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !reg_rd) begin
      rdata_q <= 8'h00;
    end else begin
      case (reg_addr)
        ADDR_PROTECT_CTRL: begin
          rdata_q <= {2'h0, protect_enable_q, hyst_q, 1'b0,
                      ref_sel_q, debounce_select_q};
        end
        ADDR_TRIM_CTRL: begin
          rdata_q <= {cmp_result, cal_mode_q, cal_ref_q, trim_q};
        end
        ADDR_DAC_CODE: begin
          rdata_q <= dac_code_q;
        end
        default: begin
          rdata_q <= 8'h00;
        end
      endcase
    end
  end

  // Two-stage synchroniser for the analog comparator output
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end else begin
      cmp_meta_q <= cmp_raw;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  assign deb_limit = deb_map(debounce_select_q);

  // Filter is held cleared while the function is off
  cmp_debounce #(
    .CNT_W (6)
  ) u_debounce (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .enable  (protect_enable_q),
    .sample  (cmp_sync_q),
    .limit   (deb_limit),
    .level_q (cmp_result),
    .rise_q  (cmp_rise)
  );

  // Analog switch drive
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      switch_q <= switch_map(CAL_MODE_RST, CAL_REF_SEL_RST);
    end else begin
      switch_q <= switch_map(cal_mode_q, cal_ref_q);
    end
  end

  // Over-voltage request pulse
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= cmp_rise && protect_enable_q && !cal_mode_q;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata          = rdata_q;
  assign cmp_power_en       = protect_enable_q;
  assign dac_power_en       = protect_enable_q;
  assign cmp_hysteresis_en  = hyst_q;
  assign dac_ref_select     = ref_sel_q;
  assign threshold_dac_code = dac_code_q;
  assign offset_trim        = trim_q;
  assign cal_mode           = cal_mode_q;
  assign cal_ref_select     = cal_ref_q;
  assign switch_close       = switch_q;
  assign irq_req            = irq_q;

  // Eight cycles of disagreement with debounce of eight selected
  sequence s_diff_8;
    (protect_enable_q && debounce_select_q == 2'h1 && cmp_sync_q != cmp_result
     && !(reg_wr && reg_addr == ADDR_PROTECT_CTRL))[*8];
  endsequence

  // Seven cycles of disagreement only
  sequence s_diff_7;
    (protect_enable_q && debounce_select_q == 2'h1 && cmp_sync_q != cmp_result
     && !(reg_wr && reg_addr == ADDR_PROTECT_CTRL))[*7];
  endsequence

  a_deb_eight_flip: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_diff_8 |=> cmp_result == $past(cmp_sync_q))
    else $error("Filtered result did not follow after eight stable cycles");

  // Fresh disagreement starts the count at zero; seven cycles must not flip
  a_deb_no_early: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $past(cmp_sync_q == cmp_result) ##0 s_diff_7 |-> cmp_result == $past(cmp_result, 6))
    else $error("Filtered result changed before eight stable cycles");

  a_deb_none_fast: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (protect_enable_q && debounce_select_q == 2'h0 && cmp_sync_q != cmp_result
     && !reg_wr) |=> cmp_result == $past(cmp_sync_q))
    else $error("Undebounced result lagged");

  a_off_clears: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!protect_enable_q
     && !(reg_wr && reg_addr == ADDR_PROTECT_CTRL && reg_wdata[BIT_PROTECT_EN]))
      |=> !cmp_result && !irq_req && !cmp_power_en && !dac_power_en)
    else $error("Disabled guard shows activity");

  a_irq_cause: assert property (@(posedge clk_sys) disable iff (!rst_b)
    irq_req |-> $past(protect_enable_q) && !$past(cal_mode_q) && $past(cmp_result)
                && !$past(cmp_result, 2))
    else $error("Interrupt without rising filtered result");

  // Request follows one cycle after the filtered result rises
  a_irq_raise: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ($rose(cmp_result) && protect_enable_q && !cal_mode_q) |=> irq_req)
    else $error("Rising result raised no interrupt");

  a_read_result: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (reg_rd && reg_addr == ADDR_TRIM_CTRL) |=>
      reg_rdata == {$past(cmp_result), $past(cal_mode_q), $past(cal_ref_q), $past(trim_q)})
    else $error("Trim register read mismatch");

  a_read_reserved: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (reg_rd && reg_addr == ADDR_PROTECT_CTRL) |=> reg_rdata[7:6] == 2'h0
      && reg_rdata[3] == 1'b0)
    else $error("Unused protect bits read nonzero");

  a_read_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data outside its cycle");

  a_switch_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ##1 switch_close == ($past(cal_mode_q) ? ($past(cal_ref_q) ? 3'h1 : 3'h6) : 3'h3))
    else $error("Switch pattern wrong for mode");

  a_trim_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (reg_wr && reg_addr == ADDR_TRIM_CTRL) |=> offset_trim == $past(reg_wdata[4:0])
      && cal_mode == $past(reg_wdata[6]) && cal_ref_select == $past(reg_wdata[5]))
    else $error("Trim register write lost");

  a_ctrl_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (reg_wr && reg_addr == ADDR_PROTECT_CTRL) |=> cmp_hysteresis_en == $past(reg_wdata[4])
      && dac_ref_select == $past(reg_wdata[2]) && dac_power_en == $past(reg_wdata[5]))
    else $error("Protect register write lost");

  a_dac_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(reg_wr && reg_addr == ADDR_DAC_CODE) |=> $stable(threshold_dac_code))
    else $error("DAC code changed without write");

endmodule : over_voltage_guard_ctrl

// ---- core/ovg_pkg.sv ----
// Function
// - Enable clear powers down comparator and DAC
// - Hysteresis bit drives comparator hysteresis enable
// - Reference select picks supply or external pin
// - Debounce field picks none, 8, 16, 32 clocks
// - Status bit shows comparator result
// - Mode bit selects normal or offset calibration
// - Calibration reference from negative or positive input
// - Five-bit offset trim resets to 10000
// - DAC output is reference over 256 times code
// - Unused first-register bits read zero
// - Comparator compares sense pin with DAC reference
// - Over-voltage event raises protection interrupt request
// - Mode and reference select drive the three switches
package ovg_pkg;

  // Register addresses on the plain register port
  localparam logic [1:0] ADDR_PROTECT_CTRL = 2'h0;
  localparam logic [1:0] ADDR_TRIM_CTRL    = 2'h1;
  localparam logic [1:0] ADDR_DAC_CODE     = 2'h2;

  // Field positions in protect_control
  localparam int BIT_PROTECT_EN  = 5;
  localparam int BIT_HYST_EN     = 4;
  localparam int BIT_DAC_REF_SEL = 2;
  localparam int BIT_DEB_HI      = 1;
  localparam int BIT_DEB_LO      = 0;

  // Field positions in comparator_trim_control
  localparam int BIT_CMP_RESULT  = 7;
  localparam int BIT_CAL_MODE    = 6;
  localparam int BIT_CAL_REF_SEL = 5;
  localparam int BIT_TRIM_HI     = 4;
  localparam int BIT_TRIM_LO     = 0;

  // Values after reset
  localparam logic       PROTECT_EN_RST  = 1'h0;
  localparam logic       HYST_EN_RST     = 1'h0;
  localparam logic       DAC_REF_SEL_RST = 1'h0;
  localparam logic [1:0] DEB_SEL_RST     = 2'h0;
  localparam logic       CAL_MODE_RST    = 1'h0;
  localparam logic       CAL_REF_SEL_RST = 1'h0;
  localparam logic [4:0] TRIM_RST        = 5'h10;
  localparam logic [7:0] DAC_CODE_RST    = 8'h00;

  // Debounce limits in system clocks (change after limit+1 stable cycles)
  localparam logic [5:0] DEB_LIMIT_NONE = 6'h00;
  localparam logic [5:0] DEB_LIMIT_8    = 6'h07;
  localparam logic [5:0] DEB_LIMIT_16   = 6'h0f;
  localparam logic [5:0] DEB_LIMIT_32   = 6'h1f;

  // System clock period
  localparam int CLK_PERIOD_NS = 25;

endpackage : ovg_pkg

// ---- core/cmp_debounce.sv ----
`timescale 1ns/1ps
module cmp_debounce
  import ovg_pkg::*;
#(
  parameter int CNT_W = 6
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             enable,
  input  wire logic             sample,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  level_q,
  output logic                  rise_q
);

  logic [CNT_W-1:0] cnt_q;

  // Stability counter and filtered level
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !enable) begin
      cnt_q   <= '0;
      level_q <= 1'b0;
    end else if (sample == level_q) begin
      cnt_q   <= '0;
    end else if (cnt_q >= limit) begin
      cnt_q   <= '0;
      level_q <= sample;
    end else begin
      cnt_q   <= cnt_q + 1'b1;
    end
  end

  // One-cycle pulse on a filtered low-to-high change
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !enable) begin
      rise_q <= 1'b0;
    end else begin
      rise_q <= (sample != level_q) && (cnt_q >= limit) && sample;
    end
  end

endmodule : cmp_debounce

// ---- verification/sense_comparator_model.sv ----
`timescale 1ns/1ps
module sense_comparator_model #(
  parameter int         VDD_MV      = 3300,
  parameter int         EXT_MV      = 2048,
  parameter int         HYST_MV     = 20,
  parameter logic [4:0] OFFSET_CODE = 5'h0b
) (
  input  var int         sense_mv,
  input  wire logic       cmp_power_en,
  input  wire logic       dac_power_en,
  input  wire logic       cmp_hysteresis_en,
  input  wire logic       dac_ref_select,
  input  wire logic [7:0] threshold_dac_code,
  input  wire logic [4:0] offset_trim,
  input  wire logic       cal_mode,
  input  wire logic       cal_ref_select,
  output logic            cmp_raw
);
  int ref_mv;
  int level_mv;

  // Threshold from the selected reference and the code
  assign ref_mv   = dac_ref_select ? EXT_MV : VDD_MV;
  assign level_mv = ref_mv * int'(threshold_dac_code) / 256;

  // Analog comparator; offset seen only in calibration
  always @* begin
    if (!(cmp_power_en && dac_power_en)) begin
      cmp_raw = 1'b0;
    end else if (cal_mode) begin
      cmp_raw = cal_ref_select ? (offset_trim > OFFSET_CODE) : (offset_trim < OFFSET_CODE);
    end else if (cmp_hysteresis_en && cmp_raw) begin
      cmp_raw = sense_mv > level_mv - HYST_MV;
    end else begin
      cmp_raw = sense_mv > level_mv;
    end
  end
endmodule : sense_comparator_model

// ---- verification/test_over_voltage_guard_ctrl.sv ----
`timescale 1ns/1ps
module test_over_voltage_guard_ctrl
  import ovg_pkg::*;
;
  localparam logic [4:0] CAL_OFF = 5'h0b;
  logic       clk_sys   = 1'b0;
  logic       rst_b     = 1'b0;
  logic [1:0] reg_addr  = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_rdata;
  logic       cmp_raw, cmp_power_en, dac_power_en, cmp_hysteresis_en, dac_ref_select;
  logic [7:0] threshold_dac_code;
  logic [4:0] offset_trim;
  logic       cal_mode, cal_ref_select, irq_req;
  logic [2:0] switch_close;
  int         sense_mv  = 0;
  int         failures  = 0;
  int         checks    = 0;
  int         irq_cnt   = 0;

  over_voltage_guard_ctrl dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp_raw(cmp_raw), .cmp_power_en(cmp_power_en), .dac_power_en(dac_power_en),
    .cmp_hysteresis_en(cmp_hysteresis_en), .dac_ref_select(dac_ref_select),
    .threshold_dac_code(threshold_dac_code), .offset_trim(offset_trim), .cal_mode(cal_mode),
    .cal_ref_select(cal_ref_select), .switch_close(switch_close), .irq_req(irq_req));

  // Sense pin is wired to the comparator from the start
  sense_comparator_model #(.OFFSET_CODE(CAL_OFF)) partner (.sense_mv(sense_mv),
    .cmp_power_en(cmp_power_en), .dac_power_en(dac_power_en),
    .cmp_hysteresis_en(cmp_hysteresis_en), .dac_ref_select(dac_ref_select),
    .threshold_dac_code(threshold_dac_code), .offset_trim(offset_trim), .cal_mode(cal_mode),
    .cal_ref_select(cal_ref_select), .cmp_raw(cmp_raw));

  // Clock and request counter
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (irq_req === 1'b1) irq_cnt++;

  task automatic summarize();
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cycles

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Reset values, unmapped read, read data standing one cycle
  task automatic t_reset();
    logic [7:0] d;
    check("switches", {5'h0, switch_close}, 8'h03);
    check("power", {6'h0, cmp_power_en, dac_power_en}, 8'h00);
    rd(ADDR_PROTECT_CTRL, d);
    check("protect_control", d, 8'h00);
    rd(ADDR_TRIM_CTRL, d);
    check("comparator_trim_control", d, 8'h10);
    rd(ADDR_DAC_CODE, d);
    check("threshold_dac_code", d, 8'h00);
    rd(2'h3, d);
    check("unmapped", d, 8'h00);
    @(posedge clk_sys);
    #1 check("rdata idle", reg_rdata, 8'h00);
  endtask : t_reset

  // Control outputs, unused bits, mode and switch table
  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] wv[3] = '{8'h9f, 8'hdf, 8'hff};
    logic [2:0] sw[3] = '{3'h3, 3'h6, 3'h1};
    wr(ADDR_PROTECT_CTRL, 8'hff);
    wr(ADDR_DAC_CODE, 8'ha5);
    wr(2'h3, 8'h00);
    cycles(2);
    #1 check("power on", {6'h0, cmp_power_en, dac_power_en}, 8'h03);
    check("hyst ref", {6'h0, cmp_hysteresis_en, dac_ref_select}, 8'h03);
    check("dac out", threshold_dac_code, 8'ha5);
    rd(ADDR_PROTECT_CTRL, d);
    check("protect_control", d, 8'h37);
    rd(ADDR_DAC_CODE, d);
    check("threshold_dac_code", d, 8'ha5);
    wr(ADDR_PROTECT_CTRL, 8'hcb);
    cycles(2);
    #1 check("power off", {5'h0, cmp_power_en, dac_power_en, cmp_hysteresis_en}, 8'h00);
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_TRIM_CTRL, wv[m]);
      cycles(2);
      #1 check("switches", {5'h0, switch_close}, {5'h0, sw[m]});
      check("mode out", {1'b0, cal_mode, cal_ref_select, offset_trim}, wv[m] & 8'h7f);
      rd(ADDR_TRIM_CTRL, d);
      check("comparator_trim_control", d, wv[m] & 8'h7f);
    end
    wr(ADDR_TRIM_CTRL, 8'h10);
  endtask : t_regs

  // Debounce length per select, one-cycle request, status bit
  task automatic t_debounce();
    logic [7:0] d;
    logic [5:0] lim[4] = '{DEB_LIMIT_NONE, DEB_LIMIT_8, DEB_LIMIT_16, DEB_LIMIT_32};
    int n;
    wr(ADDR_DAC_CODE, 8'h80);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_PROTECT_CTRL, 8'h20 | 8'(s));
      cycles(40);
      sense_mv <= 2000;
      n = 0;
      while (n < 80 && irq_req !== 1'b1) begin
        @(posedge clk_sys);
        #1 n++;
      end
      check("irq delay", 8'(n), 8'h04 + {2'h0, lim[s]});
      @(posedge clk_sys);
      #1 check("irq pulse", {7'h0, irq_req}, 8'h00);
      rd(ADDR_TRIM_CTRL, d);
      check("cmp_result", {7'h0, d[7]}, 8'h01);
      @(posedge clk_sys);
      sense_mv <= 1000;
      cycles(40);
    end
    irq_cnt = 0;
    sense_mv <= 2000;
    cycles(10);
    sense_mv <= 1000;
    cycles(50);
    check("short glitch", 8'(irq_cnt), 8'h00);
  endtask : t_debounce

  // External reference, calibration and disable suppress requests
  task automatic t_refsel();
    logic [7:0] d;
    sense_mv <= 1200;
    wr(ADDR_PROTECT_CTRL, 8'h24);
    cycles(8);
    rd(ADDR_TRIM_CTRL, d);
    check("ext ref result", {7'h0, d[7]}, 8'h01);
    wr(ADDR_PROTECT_CTRL, 8'h20);
    cycles(8);
    rd(ADDR_TRIM_CTRL, d);
    check("supply ref result", {7'h0, d[7]}, 8'h00);
    irq_cnt = 0;
    wr(ADDR_TRIM_CTRL, 8'h70);
    cycles(10);
    rd(ADDR_TRIM_CTRL, d);
    check("cal result", d, 8'hf0);
    wr(ADDR_TRIM_CTRL, 8'h10);
    wr(ADDR_PROTECT_CTRL, 8'h00);
    sense_mv <= 2000;
    cycles(10);
    rd(ADDR_TRIM_CTRL, d);
    check("disabled result", d, 8'h10);
    check("no irq", 8'(irq_cnt), 8'h00);
  endtask : t_refsel

  // Software offset sweep up and down, then the average
  task automatic t_cal();
    logic [7:0] d;
    logic       base;
    logic [4:0] lo = 5'h00;
    logic [4:0] hi = 5'h00;
    @(posedge clk_sys);
    sense_mv <= 0;
    wr(ADDR_PROTECT_CTRL, 8'h20);
    wr(ADDR_TRIM_CTRL, 8'h60);
    cycles(6);
    rd(ADDR_TRIM_CTRL, d);
    base = d[7];
    for (int i = 1; i < 32; i++) begin
      wr(ADDR_TRIM_CTRL, 8'h60 | 8'(i));
      cycles(6);
      rd(ADDR_TRIM_CTRL, d);
      lo = 5'(i);
      if (d[7] !== base) break;
    end
    wr(ADDR_TRIM_CTRL, 8'h7f);
    cycles(6);
    rd(ADDR_TRIM_CTRL, d);
    base = d[7];
    for (int i = 30; i >= 0; i--) begin
      wr(ADDR_TRIM_CTRL, 8'h60 | 8'(i));
      cycles(6);
      rd(ADDR_TRIM_CTRL, d);
      hi = 5'(i);
      if (d[7] !== base) break;
    end
    check("lower point", {3'h0, lo}, {3'h0, CAL_OFF + 5'h01});
    check("upper point", {3'h0, hi}, {3'h0, CAL_OFF});
    wr(ADDR_TRIM_CTRL, 8'(({1'b0, lo} + {1'b0, hi}) >> 1));
    cycles(2);
    #1 check("trim result", {3'h0, offset_trim}, {3'h0, CAL_OFF});
  endtask : t_cal

  // Main sequence
  initial begin
    cycles(20);
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_debounce();
    t_refsel();
    t_cal();
    summarize();
  end

  // Watchdog for a hung run
  initial begin
    cycles(20000);
    failures++;
    summarize();
  end
endmodule : test_over_voltage_guard_ctrl
